// ===== verilog/scfg_pkg.sv
// Purpose: Shared constants and types for the serializer configuration register.
// Assumes: Eight-bit register port driven by the control-bus slave engine.
// Notes: Reserved bit values follow the register's reset value.
package scfg_pkg;
   localparam logic [7:0] SCFG_ADDR_LINK_CONFIG_PRIMARY = 8'h03;
   localparam logic [7:0] SCFG_RESET_VALUE = 8'hD2;
   localparam int SCFG_BIT_CRC_EN = 7;
   localparam int SCFG_BIT_RSVD_HI = 6;
   localparam int SCFG_BIT_AUTO_ACK = 5;
   localparam int SCFG_BIT_FILTER_EN = 4;
   localparam int SCFG_BIT_PASS_THRU = 3;
   localparam int SCFG_BIT_RSVD_LO = 2;
   localparam int SCFG_BIT_CLK_AUTO = 1;
   localparam int SCFG_BIT_EDGE_SEL = 0;
   localparam logic [7:0] SCFG_WRITE_MASK = 8'hBB;
   localparam int SCFG_SYNC_WIDTH = 3;
   localparam int SCFG_FILTER_CYCLES = 2;

   typedef struct packed {
      logic de;
      logic hs;
      logic vs;
   } scfg_sync_type;
endpackage

// ===== verilog/scfg_glitch_filter.sv
// Purpose: Rejects pulses shorter than two clock cycles on each bit.
// Assumes: Inputs are already synchronised to clk.
// Notes: Accepted edges appear one cycle later than in bypass.
module scfg_glitch_filter
   import scfg_pkg::*;
#(
   parameter int WIDTH = SCFG_SYNC_WIDTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] prev_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= din;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               dout[g] <= 1'b0;
            end else if (!enable) begin
               dout[g] <= din[g];
            end else if (din[g] == prev_q[g]) begin
               dout[g] <= din[g];
            end
         end
      end
   endgenerate
endmodule // scfg_glitch_filter

// ===== verilog/scfg_config_reg.sv
// Purpose: Configuration register zero of a video link serializer and its controls.
// Assumes: Register port comes from the control-bus slave engine on clk.
// Notes: Edge select is a level for the capture stage; this block samples on rising clk.
module scfg_config_reg
   import scfg_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data,
   input wire logic wr_to_deser,
   input wire logic wr_to_other_remote,
   input wire logic pass_all_en,
   input wire logic remote_ack,
   output logic local_ack,
   input scfg_sync_type sync_in,
   output scfg_sync_type sync_out,
   input wire logic pclk_present,
   output logic osc_select,
   output logic crc_check_enable,
   output logic pass_through_enable,
   output logic pixel_clock_edge_select
);
   logic [7:0] cfg_q;
   scfg_sync_type sync_m_q;
   scfg_sync_type sync_s_q;
   logic [1:0] present_sync_q;
   logic remote_bound;
   logic [SCFG_SYNC_WIDTH-1:0] filt_out;
   logic cfg_wr_hit;

   // Address decode shared by the write, read and checker logic
   function automatic logic cfg_addr_hit(input logic [7:0] addr);
      return addr == SCFG_ADDR_LINK_CONFIG_PRIMARY;
   endfunction
   assign cfg_wr_hit = reg_wr_en & cfg_addr_hit(reg_addr);

   // Register write: reserved bits are masked so they always hold the reset value
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_q <= SCFG_RESET_VALUE;
      end else if (cfg_wr_hit) begin
         cfg_q <= (reg_wr_data & SCFG_WRITE_MASK)
                | (SCFG_RESET_VALUE & ~SCFG_WRITE_MASK);
      end
   end

   // Unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rd_data <= 8'h00;
      end else if (cfg_addr_hit(reg_addr)) begin
         reg_rd_data <= cfg_q;
      end else begin
         reg_rd_data <= 8'h00;
      end
   end

   assign crc_check_enable = cfg_q[SCFG_BIT_CRC_EN];
   assign pass_through_enable = cfg_q[SCFG_BIT_PASS_THRU];
   assign pixel_clock_edge_select = cfg_q[SCFG_BIT_EDGE_SEL];

   // Acknowledge is combinational so an auto ack costs no extra bus cycle
   assign remote_bound = wr_to_deser | (wr_to_other_remote & pass_all_en);
   always_comb begin
      if (cfg_q[SCFG_BIT_AUTO_ACK]) begin
         local_ack = remote_bound;
      end else begin
         local_ack = remote_ack;
      end
   end

   // Pin inputs pass two flip-flops before any logic sees them
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync_m_q <= '0;
         sync_s_q <= '0;
      end else begin
         sync_m_q <= sync_in;
         sync_s_q <= sync_m_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         present_sync_q <= 2'h3; // Reset as clock present, so no false switch follows reset
      end else begin
         present_sync_q <= {present_sync_q[0], pclk_present};
      end
   end

   // Clock loss only switches over when auto mode is on
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         osc_select <= 1'b0;
      end else begin
         osc_select <= cfg_q[SCFG_BIT_CLK_AUTO] & ~present_sync_q[1];
      end
   end

   scfg_glitch_filter #(
      .WIDTH(SCFG_SYNC_WIDTH)
   ) u_filter (
      .clk(clk),
      .reset_n(reset_n),
      .enable(cfg_q[SCFG_BIT_FILTER_EN]),
      .din(sync_s_q),
      .dout(filt_out)
   );
   assign sync_out = filt_out;

   // Checkers and covers; reset masks them all
   reserved_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_RSVD_HI] == 1'b1 && cfg_q[SCFG_BIT_RSVD_LO] == 1'b0)
      else $error("reserved bits changed");

   reserved_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_addr_hit(reg_addr) |=> reg_rd_data[SCFG_BIT_RSVD_HI] == 1'b1
      && reg_rd_data[SCFG_BIT_RSVD_LO] == 1'b0)
      else $error("reserved bits read wrong");

   crc_follows_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_hit |=> crc_check_enable == $past(reg_wr_data[SCFG_BIT_CRC_EN]))
      else $error("crc enable not written");

   crc_holds_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cfg_wr_hit |=> $stable(crc_check_enable))
      else $error("crc enable changed without write");

   // Ack output checks see the combinational path, so they hold in the request cycle; the enable write checks look one cycle later
   auto_ack_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_hit |=> cfg_q[SCFG_BIT_AUTO_ACK] == $past(reg_wr_data[SCFG_BIT_AUTO_ACK]))
      else $error("auto ack enable not written");

   auto_ack_now_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_AUTO_ACK] && wr_to_deser |-> local_ack)
      else $error("auto ack missing");

   auto_ack_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_AUTO_ACK] && wr_to_other_remote && pass_all_en |-> local_ack)
      else $error("pass-all auto ack missing");

   auto_ack_refuse_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_AUTO_ACK] && !wr_to_deser && !pass_all_en |-> !local_ack)
      else $error("auto ack without remote-bound write");

   remote_ack_ignored_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_AUTO_ACK] && remote_ack && !remote_bound |-> !local_ack)
      else $error("late remote ack passed in auto mode");

   wait_remote_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cfg_q[SCFG_BIT_AUTO_ACK] |-> local_ack == remote_ack)
      else $error("ack without remote");

   filter_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_hit |=> cfg_q[SCFG_BIT_FILTER_EN] == $past(reg_wr_data[SCFG_BIT_FILTER_EN]))
      else $error("filter enable not written");

   // Output low before the pulse, else a held high level would look like a pass
   short_pulse_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
      !sync_out.de && !sync_s_q.de ##1 sync_s_q.de && cfg_q[SCFG_BIT_FILTER_EN]
      ##1 !sync_s_q.de && cfg_q[SCFG_BIT_FILTER_EN] |=> !sync_out.de)
      else $error("short pulse passed");

   short_vs_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
      !sync_out.vs && !sync_s_q.vs ##1 sync_s_q.vs && cfg_q[SCFG_BIT_FILTER_EN]
      ##1 !sync_s_q.vs && cfg_q[SCFG_BIT_FILTER_EN] |=> !sync_out.vs)
      else $error("short vs pulse passed");

   long_pulse_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
      sync_s_q.hs && cfg_q[SCFG_BIT_FILTER_EN]
      ##1 sync_s_q.hs && cfg_q[SCFG_BIT_FILTER_EN] |=> sync_out.hs)
      else $error("two-cycle pulse dropped");

   filter_bypass_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cfg_q[SCFG_BIT_FILTER_EN] |=> sync_out == $past(sync_s_q))
      else $error("bypass did not follow input");

   // Switchover is only a request level; the clock mux itself sits outside this block
   clk_auto_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_hit |=> cfg_q[SCFG_BIT_CLK_AUTO] == $past(reg_wr_data[SCFG_BIT_CLK_AUTO]))
      else $error("auto switch enable not written");

   osc_switch_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_CLK_AUTO] && !present_sync_q[1] |=> osc_select)
      else $error("no oscillator switch");

   osc_release_a: assert property (@(posedge clk) disable iff (!reset_n)
      present_sync_q[1] |=> !osc_select)
      else $error("oscillator kept with clock present");

   osc_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !$past(cfg_q[SCFG_BIT_CLK_AUTO]) |-> !osc_select)
      else $error("switch while disabled");

   edge_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_hit |=> pixel_clock_edge_select == $past(reg_wr_data[SCFG_BIT_EDGE_SEL]))
      else $error("edge select not written");

   edge_holds_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cfg_wr_hit |=> $stable(pixel_clock_edge_select))
      else $error("edge select changed without write");

   // Covers for the main scenarios
   auto_ack_c: cover property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_AUTO_ACK] && local_ack);
   pass_all_ack_c: cover property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_AUTO_ACK] && wr_to_other_remote && pass_all_en && local_ack);
   filtered_c: cover property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_FILTER_EN] && sync_s_q.hs != sync_out.hs);
   short_drop_c: cover property (@(posedge clk) disable iff (!reset_n)
      cfg_q[SCFG_BIT_FILTER_EN] && sync_s_q.de ##1 !sync_s_q.de && !sync_out.de);
   osc_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(osc_select));
endmodule // scfg_config_reg

// ===== verification/scfg_remote_model.sv
// Purpose: Remote deserializer stand-in returning write acks.
// Assumes: One ack pulse per forwarded write byte.
// Notes: DLY sets how slowly the far end answers.
module scfg_remote_model #(
   parameter int DLY = 3
) (
   input wire logic clk,
   input wire logic wr_to_deser,
   output logic remote_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] pipe_q = 8'h00;
   always_ff @(posedge clk) begin
      pipe_q <= {pipe_q[6:0], wr_to_deser};
   end
   assign remote_ack = pipe_q[DLY-1];
endmodule // scfg_remote_model

// ===== verification/scfg_config_reg_tb_top.sv
// Purpose: Self-checking bench for the configuration register.
// Assumes: Inputs change on falling clk.
// Notes: Slow remote ack shows auto ack is not waiting.
module scfg_config_reg_tb_top import scfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, deser = 1'b0, other = 1'b0;
   logic pass_all = 1'b0, pclk_ok = 1'b1, rack, ack, osc, crc, pt, esel;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [2:0] seen = 3'h0;
   scfg_sync_type sin = '0, sout;
   int err_total = 0, n_checks = 0;
   scfg_config_reg dut (.clk(clk), .reset_n(reset_n), .reg_wr_en(wr_en),
      .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata), .wr_to_deser(deser),
      .wr_to_other_remote(other), .pass_all_en(pass_all), .remote_ack(rack),
      .local_ack(ack), .sync_in(sin), .sync_out(sout), .pclk_present(pclk_ok),
      .osc_select(osc), .crc_check_enable(crc), .pass_through_enable(pt),
      .pixel_clock_edge_select(esel));
   scfg_remote_model remote (.clk(clk), .wr_to_deser(deser), .remote_ack(rack));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      chk(rdata, exp);
   endtask
   // Pulse length in cycles on the chosen lines; seen gathers any output bit high
   task automatic pulse(input int n, input logic [2:0] bits, input logic [2:0] exp);
      seen = 3'h0;
      sin = bits;
      repeat (n) @(negedge clk);
      sin = '0;
      repeat (8) begin
         @(negedge clk);
         seen |= sout;
      end
      chk({5'h00, seen}, {5'h00, exp});
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      int i;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      rd(SCFG_ADDR_LINK_CONFIG_PRIMARY, SCFG_RESET_VALUE);
      chk({crc, pt, esel}, 8'h04);
      wr(8'h03, 8'h00);
      rd(8'h03, 8'h40);
      chk({crc, pt, esel}, 8'h00);
      pclk_ok = 1'b0;
      repeat (5) @(negedge clk);
      chk(osc, 8'h00);
      pulse(1, 3'h7, 3'h7);
      deser = 1'b1;
      #1 chk(ack, 8'h00);
      @(negedge clk);
      deser = 1'b0;
      i = 0;
      while (ack !== 1'b1 && i < 10) begin
         @(negedge clk);
         i++;
      end
      chk(ack, 8'h01);
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'hFB);
      chk({crc, pt, esel, osc}, 8'h0F);
      pclk_ok = 1'b1;
      repeat (5) @(negedge clk);
      chk(osc, 8'h00);
      pulse(1, 3'h7, 3'h0);
      pulse(2, 3'h2, 3'h2);
      pulse(3, 3'h5, 3'h5);
      other = 1'b1;
      #1 chk(ack, 8'h00);
      @(negedge clk);
      pass_all = 1'b1;
      #1 chk(ack, 8'h01);
      @(negedge clk);
      other = 1'b0;
      deser = 1'b1;
      #1 chk(ack, 8'h01);
      @(negedge clk);
      deser = 1'b0;
      wr(8'h04, 8'h00);
      rd(8'h03, 8'hFB);
      rd(8'h04, 8'h00);
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      rd(8'h03, SCFG_RESET_VALUE);
      chk(osc, 8'h00);
      end_sim;
   end
endmodule // scfg_config_reg_tb_top
